// file: design/udp_consts.vh
`ifndef UDP_CONSTS_VH
`define UDP_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Avalon-MM slave.
`define UDP_OFS_DATA      5'h00
`define UDP_OFS_CSA       5'h04
`define UDP_OFS_CSB       5'h08
`define UDP_OFS_CSC       5'h0C
`define UDP_OFS_BAUD      5'h10

////////////////////////////////////////////////////////////////////////////////
// Bit positions in ctrl_status_a.
`define UDP_CSA_RXDONE    7
`define UDP_CSA_TXDONE    6
`define UDP_CSA_TXBE      5
`define UDP_CSA_FRMERR    4
`define UDP_CSA_OVR       3
`define UDP_CSA_PARERR    2

// Bit positions in ctrl_status_b.
`define UDP_CSB_RXDONE_IE 7
`define UDP_CSB_DONE_IE   6
`define UDP_CSB_EMPTY_IE  5
`define UDP_CSB_RXON      4
`define UDP_CSB_TXON      3
`define UDP_CSB_SIZE2     2
`define UDP_CSB_RX9       1
`define UDP_CSB_TX9       0

// Bit positions in the frame format register.
`define UDP_CSC_SYNC      6
`define UDP_CSC_PAREN     5
`define UDP_CSC_PARODD    4
`define UDP_CSC_STOP2     3
`define UDP_CSC_SIZE_HI   2
`define UDP_CSC_SIZE_LO   1

////////////////////////////////////////////////////////////////////////////////
// Reset values and encodings.
`define UDP_CSB_RST       8'h00
`define UDP_CSC_RST       8'h06
`define UDP_BAUD_RST      16'h0009
`define UDP_SIZE_NINE     3'h7
`define UDP_NBITS_NINE    4'h9
`define UDP_NBITS_BASE    4'h5

`endif

// file: design/udp_bit_timer.v
module udp_bit_timer (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Control
	input  wire        hold,
	input  wire        half_sel,
	input  wire [15:0] divisor,
	// Bit strobe
	output wire        tick
);

	reg [15:0] count_reg;
	reg [15:0] count_next;

	// While held the counter is preloaded, so the first strobe after release lands
	// half a bit later (receiver start check) or one full bit later (transmitter).
	always @* begin
		if (hold)
			count_next = half_sel ? {1'b0, divisor[15:1]} : divisor;
		else if (count_reg == 16'h0000)
			count_next = divisor;
		else
			count_next = count_reg - 16'h0001;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count_reg <= 16'h0000;
		else
			count_reg <= count_next;
	end

	assign tick = ~hold & (count_reg == 16'h0000);

endmodule // udp_bit_timer

// file: design/udp_datapath.v
// Operation
// [RULE1] Nine-bit characters take bit eight from tx_ninth_bit, set before the data write.
// [RULE2] tx_buffer_empty is one when the transmit buffer is empty, else zero.
// [RULE3] Writing data_buffer_port loads the transmit buffer and clears tx_buffer_empty.
// [RULE4] Empty interrupt stays high while empty and enabled, gated by global enable.
// [RULE5] tx_complete sets when the frame is shifted out and no character waits.
// [RULE6] tx_complete clears on interrupt service or on a written one.
// [RULE7] Transmit-complete interrupt rises when tx_complete sets, if enabled globally.
// [RULE8] Parity enabled inserts parity after the last data bit, before stop.
// [RULE9] Transmitter disable waits until shifter and buffer are both empty.
// [RULE10] A truly disabled transmitter releases the serial output pin.
// [RULE11] receiver_on makes the receiver take the serial input pin.
// [RULE12] Synchronous mode clocks the receiver from the sync clock pin.
// [RULE13] Reception starts on a valid start bit and samples up to stop.
// [RULE14] Only the first stop bit is checked; a second is ignored.
// [RULE15] At the first stop bit the frame moves into the receive buffer.
// [RULE16] Characters under eight bits read back with zero upper bits.
// [RULE17] Ninth bit and error flags travel per entry; reading data advances.
// [RULE18] Software reads status and ninth bit before the low data byte.
// [RULE19] Software writes zero to the tx_buffer_empty position.
// [RULE20] The shifter takes the next character when idle or after last stop.
// [RULE21] Frame is low start, data LSB first, parity, stops; idle high.
// [RULE22] rx_complete is one while unread received data exist.
// [RULE23] Two-entry receive buffer; overrun when full, one waits, new start.
// [RULE24] One data address: writes feed transmit, reads return oldest receive.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`include "udp_consts.vh"

module udp_datapath (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// Avalon-MM slave
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// Serial pins
	input  wire        rxd,
	input  wire        sync_clock_pin,
	output wire        txd_out,
	output reg         txd_en,
	output wire        rxd_en,
	// Interrupt requests
	input  wire        global_irq_en,
	input  wire        tx_done_irq_ack,
	output wire        irq_tx_empty,
	output wire        irq_tx_done,
	output wire        irq_rx_done
);

	localparam [1:0] T_IDLE  = 2'b01;
	localparam [1:0] T_SHIFT = 2'b10;
	localparam [1:0] R_IDLE  = 2'b01;
	localparam [1:0] R_BITS  = 2'b10;
	localparam [7:0] CSB_RST = `UDP_CSB_RST;
	localparam [7:0] CSC_RST = `UDP_CSC_RST;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release, pin synchronisers, bus handshake.

	reg        rst_q1_reg;
	reg        rst_n_reg;
	reg        rxd_q1_reg;
	reg        rxd_s_reg;
	reg        xck_q1_reg;
	reg        xck_s_reg;
	reg        xck_d_reg;
	reg        ack_reg;
	wire       rst_n = rst_n_reg;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_n_reg  <= rst_q1_reg;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_q1_reg <= 1'b1;
			rxd_s_reg  <= 1'b1;
			xck_q1_reg <= 1'b0;
			xck_s_reg  <= 1'b0;
			xck_d_reg  <= 1'b0;
			ack_reg    <= 1'b0;
		end else begin
			rxd_q1_reg <= rxd;
			rxd_s_reg  <= rxd_q1_reg;
			xck_q1_reg <= sync_clock_pin;
			xck_s_reg  <= xck_q1_reg;
			xck_d_reg  <= xck_s_reg;
			ack_reg    <= (avs_read | avs_write) & ~ack_reg;
		end
	end

	// Every access costs two cycles: read data are registered in the first.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	wire xck_rise = xck_s_reg & ~xck_d_reg;
	wire xck_fall = ~xck_s_reg & xck_d_reg;
	wire wr_go    = avs_write & ack_reg;
	wire rd_go    = avs_read & ack_reg;
	wire wr_lo    = wr_go & avs_byteenable[0];
	wire wr_data  = wr_lo & (avs_address == `UDP_OFS_DATA);
	wire rd_data  = rd_go & (avs_address == `UDP_OFS_DATA);

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	reg        rxdone_irq_en_reg;
	reg        tx_done_irq_en_reg;
	reg        tx_empty_irq_en_reg;
	reg        receiver_on_reg;
	reg        transmitter_on_reg;
	reg        tx_ninth_bit_reg;
	reg        sync_mode_reg;
	reg        parity_enable_reg;
	reg        parity_odd_reg;
	reg        two_stop_reg;
	reg [2:0]  char_size_sel_reg;
	reg [15:0] baud_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxdone_irq_en_reg  <= CSB_RST[`UDP_CSB_RXDONE_IE];
			tx_done_irq_en_reg <= CSB_RST[`UDP_CSB_DONE_IE];
			tx_empty_irq_en_reg <= CSB_RST[`UDP_CSB_EMPTY_IE];
			receiver_on_reg    <= CSB_RST[`UDP_CSB_RXON];
			transmitter_on_reg <= CSB_RST[`UDP_CSB_TXON];
			tx_ninth_bit_reg   <= CSB_RST[`UDP_CSB_TX9];
			sync_mode_reg      <= CSC_RST[`UDP_CSC_SYNC];
			parity_enable_reg  <= CSC_RST[`UDP_CSC_PAREN];
			parity_odd_reg     <= CSC_RST[`UDP_CSC_PARODD];
			two_stop_reg       <= CSC_RST[`UDP_CSC_STOP2];
			char_size_sel_reg  <= {CSB_RST[`UDP_CSB_SIZE2], CSC_RST[`UDP_CSC_SIZE_HI:`UDP_CSC_SIZE_LO]};
			baud_reg           <= `UDP_BAUD_RST;
		end else begin
			if (wr_lo && avs_address == `UDP_OFS_CSB) begin
				rxdone_irq_en_reg    <= avs_writedata[`UDP_CSB_RXDONE_IE];
				tx_done_irq_en_reg   <= avs_writedata[`UDP_CSB_DONE_IE];
				tx_empty_irq_en_reg  <= avs_writedata[`UDP_CSB_EMPTY_IE];
				receiver_on_reg      <= avs_writedata[`UDP_CSB_RXON];
				transmitter_on_reg   <= avs_writedata[`UDP_CSB_TXON];
				char_size_sel_reg[2] <= avs_writedata[`UDP_CSB_SIZE2];
				tx_ninth_bit_reg     <= avs_writedata[`UDP_CSB_TX9]; // [RULE1]
			end
			if (wr_lo && avs_address == `UDP_OFS_CSC) begin
				sync_mode_reg          <= avs_writedata[`UDP_CSC_SYNC];
				parity_enable_reg      <= avs_writedata[`UDP_CSC_PAREN];
				parity_odd_reg         <= avs_writedata[`UDP_CSC_PARODD];
				two_stop_reg           <= avs_writedata[`UDP_CSC_STOP2];
				char_size_sel_reg[1:0] <= avs_writedata[`UDP_CSC_SIZE_HI:`UDP_CSC_SIZE_LO];
			end
			if (wr_lo && avs_address == `UDP_OFS_BAUD)
				baud_reg[7:0] <= avs_writedata[7:0];
			if (wr_go && avs_byteenable[1] && avs_address == `UDP_OFS_BAUD)
				baud_reg[15:8] <= avs_writedata[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame format helpers shared by both directions.

	function [8:0] mask_data;
		input [8:0] d;
		input [3:0] n;
		integer k;
		begin
			for (k = 0; k < 9; k = k + 1)
				mask_data[k] = (k < n) ? d[k] : 1'b0;
		end
	endfunction

	function parity_of;
		input [8:0] d;
		input       odd;
		begin
			parity_of = (^d) ^ odd;
		end
	endfunction

	wire [3:0] nbits = (char_size_sel_reg == `UDP_SIZE_NINE) ? `UDP_NBITS_NINE :
		(`UDP_NBITS_BASE + {2'b00, char_size_sel_reg[1:0]});
	wire [3:0] par_len = {3'b000, parity_enable_reg};

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter.

	reg  [8:0]  txbuf_reg;
	reg         txbuf_full_reg;
	reg  [12:0] tsh_reg;
	reg  [3:0]  tcnt_reg;
	reg  [1:0]  tstate_reg;
	reg         tx_complete_reg;
	reg  [12:0] tframe;
	reg  [8:0]  tdata;
	integer     i;
	wire        ttmr_tick;

	wire tshift   = (tstate_reg == T_SHIFT);
	wire tx_tick  = sync_mode_reg ? xck_fall : ttmr_tick;
	// Once the pin is released it stays released until software enables again.
	wire tx_live  = transmitter_on_reg | (txd_en & (tshift | txbuf_full_reg)); // [RULE9]
	wire tx_last  = tshift & tx_tick & (tcnt_reg == 4'h1);
	wire tx_load  = txbuf_full_reg & tx_live & (~tshift | tx_last); // [RULE20]
	wire [3:0] tlen = 4'h2 + nbits + par_len + {3'b000, two_stop_reg};

	always @* begin
		tdata  = mask_data(txbuf_reg, nbits);
		tframe = 13'h1FFF;
		tframe[0] = 1'b0; // [RULE21]
		for (i = 0; i < 9; i = i + 1)
			if (i < nbits)
				tframe[i + 1] = tdata[i];
		if (parity_enable_reg)
			tframe[nbits + 4'h1] = parity_of(tdata, parity_odd_reg); // [RULE8]
	end

	udp_bit_timer u_tx_timer (
		.clk      (clk),
		.rst_n    (rst_n),
		.hold     (~tshift),
		.half_sel (1'b0),
		.divisor  (baud_reg),
		.tick     (ttmr_tick)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txbuf_reg       <= 9'h000;
			txbuf_full_reg  <= 1'b0;
			tsh_reg         <= 13'h1FFF;
			tcnt_reg        <= 4'h0;
			tstate_reg      <= T_IDLE;
			tx_complete_reg <= 1'b0;
			txd_en          <= 1'b0;
		end else begin
			txd_en <= tx_live; // [RULE10]
			case (tstate_reg)
				T_IDLE: begin
					if (tx_load) begin
						tsh_reg    <= tframe;
						tcnt_reg   <= tlen;
						tstate_reg <= T_SHIFT;
					end
				end
				T_SHIFT: begin
					if (tx_load) begin
						tsh_reg  <= tframe;
						tcnt_reg <= tlen;
					end else if (tx_last) begin
						tsh_reg    <= 13'h1FFF;
						tstate_reg <= T_IDLE;
					end else if (tx_tick) begin
						tsh_reg  <= {1'b1, tsh_reg[12:1]}; // [RULE21]
						tcnt_reg <= tcnt_reg - 4'h1;
					end
				end
				default: begin
					tstate_reg <= T_IDLE;
				end
			endcase
			if (tx_load)
				txbuf_full_reg <= 1'b0; // [RULE2]
			if (wr_data) begin
				txbuf_reg      <= {tx_ninth_bit_reg, avs_writedata[7:0]}; // [RULE1]
				txbuf_full_reg <= 1'b1; // [RULE3] [RULE24]
			end
			// A frame ending in the same cycle as a clear still leaves the flag set.
			if (tx_last && !tx_load)
				tx_complete_reg <= 1'b1; // [RULE5]
			else if (tx_done_irq_ack || (wr_lo && avs_address == `UDP_OFS_CSA &&
				avs_writedata[`UDP_CSA_TXDONE]))
				tx_complete_reg <= 1'b0; // [RULE6]
		end
	end

	assign txd_out = tsh_reg[0];

	////////////////////////////////////////////////////////////////////////////////
	// Receiver.

	reg  [1:0]  rstate_reg;
	reg  [3:0]  rcnt_reg;
	reg  [9:0]  rsh_reg;
	reg  [10:0] held_reg;
	reg         held_valid_reg;
	reg         ovr_pending_reg;
	reg  [11:0] fifo_mem [0:1];
	reg         wp_reg;
	reg         rp_reg;
	reg  [1:0]  fcnt_reg;
	reg  [8:0]  rdata;
	wire        rtmr_tick;

	wire ridle     = (rstate_reg == R_IDLE);
	wire rx_hold   = ~receiver_on_reg | (ridle & rxd_s_reg);
	wire rx_tick   = receiver_on_reg & (sync_mode_reg ? xck_rise : rtmr_tick); // [RULE12]
	wire rx_start  = ridle & rx_tick & ~rxd_s_reg; // [RULE13]
	wire [3:0] rlast = nbits + par_len + 4'h1;
	wire rx_stop   = (rstate_reg == R_BITS) & rx_tick & (rcnt_reg == rlast);
	wire fifo_pop  = rd_data & (fcnt_reg != 2'h0); // [RULE24]
	wire fifo_push = held_valid_reg & ((fcnt_reg != 2'h2) | fifo_pop);
	wire [11:0] head = fifo_mem[rp_reg];
	wire rx_has    = (fcnt_reg != 2'h0);

	always @* begin
		rdata = mask_data(rsh_reg[8:0], nbits); // [RULE16]
	end

	udp_bit_timer u_rx_timer (
		.clk      (clk),
		.rst_n    (rst_n),
		.hold     (rx_hold),
		.half_sel (ridle),
		.divisor  (baud_reg),
		.tick     (rtmr_tick)
	);

	// Storage needs no reset: flags and ninth bit are masked while empty, but a data read shows the head entry unmasked.
	always @(posedge clk) begin
		if (fifo_push)
			fifo_mem[wp_reg] <= {held_reg[10], ovr_pending_reg, held_reg[9:0]}; // [RULE17]
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstate_reg      <= R_IDLE;
			rcnt_reg        <= 4'h0;
			rsh_reg         <= 10'h000;
			held_reg        <= 11'h000;
			held_valid_reg  <= 1'b0;
			ovr_pending_reg <= 1'b0;
			wp_reg          <= 1'b0;
			rp_reg          <= 1'b0;
			fcnt_reg        <= 2'h0;
		end else if (!receiver_on_reg) begin
			// Disabling is immediate and drops everything already received.
			rstate_reg      <= R_IDLE;
			held_valid_reg  <= 1'b0;
			ovr_pending_reg <= 1'b0;
			fcnt_reg        <= 2'h0;
			rp_reg          <= wp_reg;
		end else begin
			case (rstate_reg)
				R_IDLE: begin
					if (rx_start) begin
						rstate_reg <= R_BITS;
						rcnt_reg   <= 4'h1;
					end
				end
				R_BITS: begin
					if (rx_stop) begin
						// Only the first stop bit is sampled; the line then idles.
						rstate_reg <= R_IDLE; // [RULE14]
						held_reg   <= {~rxd_s_reg, parity_enable_reg &
							(parity_of(rdata, parity_odd_reg) != rsh_reg[nbits]), rdata}; // [RULE15]
					end else if (rx_tick) begin
						rsh_reg[rcnt_reg - 4'h1] <= rxd_s_reg; // [RULE13]
						rcnt_reg <= rcnt_reg + 4'h1;
					end
				end
				default: begin
					rstate_reg <= R_IDLE;
				end
			endcase
			if (fifo_push) begin
				wp_reg          <= ~wp_reg;
				ovr_pending_reg <= 1'b0;
			end
			// The waiting character is lost when the next one starts; a push in that cycle wins.
			if (rx_start && held_valid_reg && !fifo_push)
				ovr_pending_reg <= 1'b1; // [RULE23]
			if (rx_stop)
				held_valid_reg <= 1'b1;
			else if (fifo_push || rx_start)
				held_valid_reg <= 1'b0;
			if (fifo_pop)
				rp_reg <= ~rp_reg; // [RULE17]
			fcnt_reg <= fcnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop}; // [RULE23]
		end
	end

	assign rxd_en = receiver_on_reg; // [RULE11]

	////////////////////////////////////////////////////////////////////////////////
	// Read data and interrupt requests.

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !ack_reg) begin
			case (avs_address)
				`UDP_OFS_DATA: avs_readdata <= {24'h000000, head[7:0]}; // [RULE15] [RULE24]
				`UDP_OFS_CSA:  avs_readdata <= {24'h000000, rx_has, tx_complete_reg,
					~txbuf_full_reg, rx_has & head[11], rx_has & head[10],
					rx_has & head[9], 2'b00}; // [RULE2] [RULE22]
				`UDP_OFS_CSB:  avs_readdata <= {24'h000000, rxdone_irq_en_reg,
					tx_done_irq_en_reg, tx_empty_irq_en_reg, receiver_on_reg,
					transmitter_on_reg, char_size_sel_reg[2], rx_has & head[8],
					tx_ninth_bit_reg}; // [RULE17]
				`UDP_OFS_CSC:  avs_readdata <= {25'h0, sync_mode_reg,
					parity_enable_reg, parity_odd_reg, two_stop_reg,
					char_size_sel_reg[1:0], 1'b0};
				`UDP_OFS_BAUD: avs_readdata <= {16'h0000, baud_reg};
				default:       avs_readdata <= 32'h00000000;
			endcase
		end
	end

	assign irq_tx_empty = global_irq_en & tx_empty_irq_en_reg & ~txbuf_full_reg; // [RULE4]
	assign irq_tx_done  = global_irq_en & tx_done_irq_en_reg & tx_complete_reg; // [RULE7]
	assign irq_rx_done  = global_irq_en & rxdone_irq_en_reg & rx_has;

endmodule // udp_datapath

// file: verification/udp_datapath_monitor.sv
`include "udp_consts.vh"

module udp_datapath_monitor (
	// Clock and reset
	input wire        clk,
	input wire        rst_b,
	// Avalon-MM slave
	input wire [4:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Serial pins
	input wire        rxd,
	input wire        sync_clock_pin,
	input wire        txd_out,
	input wire        txd_en,
	input wire        rxd_en,
	// Interrupt requests
	input wire        global_irq_en,
	input wire        tx_done_irq_ack,
	input wire        irq_tx_empty,
	input wire        irq_tx_done,
	input wire        irq_rx_done
);
	timeunit 1ns;
	timeprecision 1ns;

	// The enables live inside the block, so a copy is kept from the bus writes.
	logic [7:0] csb_sh;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			csb_sh <= 8'h00;
		end else if (avs_write && !avs_waitrequest && avs_address == `UDP_OFS_CSB && avs_byteenable[0]) begin
			csb_sh <= avs_writedata[7:0];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_bus_req;
		(avs_read || avs_write) && !$past(avs_read || avs_write);
	endsequence
	sequence s_data_write;
		avs_write && !avs_waitrequest && avs_address == `UDP_OFS_DATA && avs_byteenable[0];
	endsequence
	sequence s_low_bit;
		!txd_out [*4];
	endsequence

	a_bus_one_wait: assert property (s_bus_req |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	a_write_clears_empty: assert property ((s_data_write ##0 (global_irq_en && csb_sh[5])) |=> !irq_tx_empty)
		else $error("empty request survived a data write");
	a_empty_irq_gate: assert property (irq_tx_empty |-> global_irq_en && csb_sh[`UDP_CSB_EMPTY_IE])
		else $error("empty request without its enables");
	a_done_irq_gate: assert property (irq_tx_done |-> global_irq_en && csb_sh[`UDP_CSB_DONE_IE])
		else $error("complete request without its enables");
	a_done_after_stop: assert property ($rose(irq_tx_done) && $stable(global_irq_en) && $stable(csb_sh[6])
		|-> txd_out && $past(txd_out, 3))
		else $error("complete raised before the stop bit ended");
	a_ack_clears_done: assert property (tx_done_irq_ack && irq_tx_done |=> !irq_tx_done)
		else $error("service did not clear complete");
	a_pin_held_low: assert property (txd_en && !txd_out |=> txd_en)
		else $error("pin released inside a frame");
	a_idle_pin_high: assert property (!txd_en |-> txd_out)
		else $error("released pin not idle high");
	a_bit_width_min: assert property ($fell(txd_out) |-> s_low_bit)
		else $error("low bit shorter than a bit time");
	a_rx_takes_pin: assert property ($rose(csb_sh[`UDP_CSB_RXON]) |-> ##[0:3] rxd_en)
		else $error("receiver did not take the pin");
	a_rx_irq_gate: assert property (irq_rx_done |-> global_irq_en && csb_sh[`UDP_CSB_RXDONE_IE])
		else $error("receive request without its enables");
endmodule // udp_datapath_monitor

bind udp_datapath udp_datapath_monitor u_mon (
	.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .rxd, .sync_clock_pin, .txd_out, .txd_en, .rxd_en,
	.global_irq_en, .tx_done_irq_ack, .irq_tx_empty, .irq_tx_done, .irq_rx_done
);

// file: verification/udp_serial_node.sv
module udp_serial_node (
	// Clock
	input  wire  clk,
	// Serial lines
	input  wire  txd_out,
	output logic rxd,
	output logic sync_clock_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		rxd = 1'b1;
		sync_clock_pin = 1'b0;
	end

	// Async bits last four clocks, the bit time of a divisor of three.
	// The sync clock stands low between frames so no stray edge is sampled.
	task automatic send_frame(input logic [8:0] d, input int nb, input logic sync_mode);
		logic b;
		for (int i = 0; i <= nb + 1; i++) begin
			b = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
			rxd <= b;
			repeat (sync_mode ? 8 : 4) @(posedge clk);
			if (sync_mode) begin
				sync_clock_pin <= 1'b1;
				repeat (8) @(posedge clk);
				sync_clock_pin <= 1'b0;
			end
		end
		rxd <= 1'b1;
		@(posedge clk);
	endtask

	// Samples each bit in its middle; a missing start leaves the result unknown.
	task automatic grab_frame(input int nb, output logic [11:0] got);
		int n;
		n = 0;
		got = 'x;
		while (txd_out !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n < 3000) begin
			for (int i = 0; i <= nb; i++) begin
				repeat (i == 0 ? 2 : 4) @(posedge clk);
				got[i] = txd_out;
			end
		end
	endtask
endmodule // udp_serial_node

// file: verification/udp_datapath_tb.sv
`include "udp_consts.vh"

module udp_datapath_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst_b, avs_read, avs_write, global_irq_en, tx_done_irq_ack;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, q;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, rxd, sync_clock_pin, txd_out, txd_en, rxd_en;
	wire         irq_tx_empty, irq_tx_done, irq_rx_done;
	logic [11:0] f1, f2;
	int          fails, n_compared;

	always #25 clk = ~clk;

	udp_datapath dut (
		.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .rxd, .sync_clock_pin,
		.txd_out, .txd_en, .rxd_en, .global_irq_en, .tx_done_irq_ack,
		.irq_tx_empty, .irq_tx_done, .irq_rx_done
	);
	udp_serial_node node (.clk, .txd_out, .rxd, .sync_clock_pin);

	////////////////////////////////////////
	task automatic stop_test();
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fails++;
			stop_test();
		end
		@(posedge clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 8'h00);
	endtask

	////////////////////////////////////////
	task automatic t_reset_values();
		rd(`UDP_OFS_CSA);
		chk(q, 32'h20);
		rd(`UDP_OFS_CSC);
		chk(q, 32'h06);
		rd(`UDP_OFS_BAUD);
		chk(q, 32'h09);
		wr(5'h14, 8'hFF);
		rd(5'h14);
		chk(q, 32'h00);
		rd(`UDP_OFS_CSB);
		chk(q, 32'h00);
	endtask

	task automatic t_tx_eight();
		wr(`UDP_OFS_BAUD, 8'h03);
		wr(`UDP_OFS_CSB, 8'h68);
		chk(irq_tx_empty, 1'b1);
		global_irq_en <= 1'b0;
		@(posedge clk);
		chk(irq_tx_empty, 1'b0);
		global_irq_en <= 1'b1;
		fork
			begin
				node.grab_frame(9, f1);
				node.grab_frame(9, f2);
			end
			begin
				wr(`UDP_OFS_DATA, 8'hA5);
				wr(`UDP_OFS_DATA, 8'h5A);
				rd(`UDP_OFS_CSA);
				chk(q & 32'h60, 32'h00);
			end
		join
		chk(f1[9:0], {1'b1, 8'hA5, 1'b0});
		chk(f2[9:0], {1'b1, 8'h5A, 1'b0});
		repeat (8) @(posedge clk);
		rd(`UDP_OFS_CSA);
		chk(q & 32'h60, 32'h60);
		chk(irq_tx_done, 1'b1);
		tx_done_irq_ack <= 1'b1;
		@(posedge clk);
		tx_done_irq_ack <= 1'b0;
		@(posedge clk);
		chk(irq_tx_done, 1'b0);
	endtask

	task automatic t_tx_nine_parity();
		wr(`UDP_OFS_CSC, 8'h26);
		wr(`UDP_OFS_CSB, 8'h0D);
		fork
			node.grab_frame(11, f1);
			wr(`UDP_OFS_DATA, 8'h3C);
		join
		chk(f1, {1'b1, 1'b1, 1'b1, 8'h3C, 1'b0});
		repeat (8) @(posedge clk);
		rd(`UDP_OFS_CSA);
		chk(q & 32'h40, 32'h40);
		wr(`UDP_OFS_CSA, 8'h40);
		rd(`UDP_OFS_CSA);
		chk(q & 32'h40, 32'h00);
	endtask

	task automatic t_tx_disable();
		wr(`UDP_OFS_CSC, 8'h06);
		wr(`UDP_OFS_CSB, 8'h08);
		fork
			node.grab_frame(9, f1);
			begin
				wr(`UDP_OFS_DATA, 8'h0F);
				wr(`UDP_OFS_CSB, 8'h00);
				chk(txd_en, 1'b1);
			end
		join
		chk(f1[9:0], {1'b1, 8'h0F, 1'b0});
		repeat (8) @(posedge clk);
		chk(txd_en, 1'b0);
	endtask

	// The first frame carries eight bits into a seven-bit receiver; the
	// third is lost to the fourth, which arrives flagged as an overrun.
	task automatic t_rx_fifo();
		logic [31:0] e [3];
		e = '{32'h2A, 32'h51, 32'h33};
		wr(`UDP_OFS_CSC, 8'h04);
		wr(`UDP_OFS_CSB, 8'h90);
		repeat (2) @(posedge clk);
		chk(rxd_en, 1'b1);
		node.send_frame(9'h0AA, 8, 1'b0);
		node.send_frame(9'h051, 7, 1'b0);
		node.send_frame(9'h07F, 7, 1'b0);
		node.send_frame(9'h033, 7, 1'b0);
		repeat (8) @(posedge clk);
		chk(irq_rx_done, 1'b1);
		for (int i = 0; i < 3; i++) begin
			rd(`UDP_OFS_CSA);
			chk(q & 32'h98, i == 2 ? 32'h88 : 32'h80);
			rd(`UDP_OFS_DATA);
			chk(q, e[i]);
		end
		rd(`UDP_OFS_CSA);
		chk(q & 32'h80, 32'h00);
	endtask

	task automatic t_sync_rx();
		wr(`UDP_OFS_CSC, 8'h46);
		wr(`UDP_OFS_CSB, 8'h10);
		node.send_frame(9'h0C3, 8, 1'b1);
		repeat (8) @(posedge clk);
		rd(`UDP_OFS_CSA);
		chk(q & 32'h80, 32'h80);
		rd(`UDP_OFS_DATA);
		chk(q, 32'hC3);
		wr(`UDP_OFS_CSB, 8'h00);
		repeat (2) @(posedge clk);
		chk(rxd_en, 1'b0);
	endtask

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		global_irq_en = 1'b1;
		tx_done_irq_ack = 1'b0;
		fails = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_values();
		t_tx_eight();
		t_tx_nine_parity();
		t_tx_disable();
		t_rx_fifo();
		t_sync_rx();
		stop_test();
	end
endmodule // udp_datapath_tb
